// File: verilog/dcic_top.sv
// Functional notes
// - eight enable bits 23:16 per channel, one enables that event's request
// - bit 20 enables the destination half-full event
// - source-done flag bit 7 sets when source pointer equals source size
// - source-half flag bit 6 sets when source pointer equals half the size
// - destination-done flag bit 5 sets when destination pointer equals size
// - eight flags in bits 7:0, source done down to address error
// - bits 31:24 read zero, writes ignored
// - bits 15:8 read zero, writes ignored
// - all enables and flags reset to zero, all software read/write
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module dcic_top #(
  parameter int NUM_CH = 4,
  parameter int PW = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcic_pkg::DCIC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // channel pointer datapath, channel c in slice c
  input wire logic [NUM_CH*PW-1:0] source_pointer,
  input wire logic [NUM_CH*PW-1:0] source_size,
  input wire logic [NUM_CH*PW-1:0] destination_pointer,
  input wire logic [NUM_CH*PW-1:0] destination_size,
  // channel datapath event pulses
  input wire logic [NUM_CH-1:0] block_done_evt,
  input wire logic [NUM_CH-1:0] cell_done_evt,
  input wire logic [NUM_CH-1:0] abort_evt,
  input wire logic [NUM_CH-1:0] addr_err_evt,
  // interrupt requests
  output logic [NUM_CH-1:0] chan_irq,
  output logic irq
);
  import dcic_pkg::*;

  localparam int WW = DCIC_AW - 2;
  localparam logic [WW-1:0] NCH_W = WW'(NUM_CH);
  localparam logic [WW-1:0] BASE_W = DCIC_CH_BASE_OFS[DCIC_AW-1:2];

  logic acc_setup;
  logic acc_phase;
  logic [WW-1:0] widx;
  logic [WW-1:0] ch_idx;
  logic ch_hit;
  logic st_hit;
  logic mk_hit;
  logic pd_hit;
  logic map_hit;
  logic wr_en;
  logic [31:0] lane_mask;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;

  logic [NUM_CH-1:0][7:0] en_q;
  logic [NUM_CH-1:0][7:0] flg_q;
  logic [NUM_CH-1:0][7:0] set_w;
  logic [NUM_CH-1:0] ch_wr;

  logic [NUM_CH-1:0] chan_irq_q;
  logic [NUM_CH-1:0] chan_rise;
  logic [NUM_CH-1:0] gst_q;
  logic [NUM_CH-1:0] gst_d;
  logic [NUM_CH-1:0] gmask_q;
  logic [NUM_CH-1:0] st_clr;

  // address decode
  always_comb begin
    acc_setup = psel & ~penable;
    acc_phase = psel & penable;
    widx = paddr[DCIC_AW-1:2];
    ch_idx = widx - BASE_W;
    ch_hit = (widx >= BASE_W) && (ch_idx < NCH_W);
    st_hit = paddr == DCIC_STATUS_OFS;
    mk_hit = paddr == DCIC_MASK_OFS;
    pd_hit = paddr == DCIC_PEND_OFS;
    map_hit = ch_hit | st_hit | mk_hit | pd_hit;
    wr_en = acc_phase & pwrite & map_hit;
    lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                 {8{pstrb[0]}}};
  end

  // zero wait states; the read word is captured in setup, so the
  // access phase can complete at once from a flip-flop
  assign pready = 1'b1;
  assign pslverr = acc_phase & ~map_hit;
  assign prdata = prdata_q;

  // read mux
  always_comb begin
    rd_d = '0;
    if (ch_hit) begin
      rd_d[DCIC_EN_LSB +: 8] = en_q[ch_idx];
      rd_d[DCIC_FLG_LSB +: 8] = flg_q[ch_idx];
    end else if (st_hit) begin
      rd_d[NUM_CH-1:0] = gst_q;
    end else if (mk_hit) begin
      rd_d[NUM_CH-1:0] = gmask_q;
    end else if (pd_hit) begin
      rd_d[NUM_CH-1:0] = chan_irq;
    end
  end

  // in a channel word bits 31:24 and 15:8 are never loaded, so they read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (acc_setup && !pwrite) begin
      prdata_q <= rd_d;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      dcic_event_detect #(
        .PW(PW)
      ) u_det (
        .pclk(pclk),
        .presetn(presetn),
        .source_pointer(source_pointer[c*PW +: PW]),
        .source_size(source_size[c*PW +: PW]),
        .destination_pointer(destination_pointer[c*PW +: PW]),
        .destination_size(destination_size[c*PW +: PW]),
        .block_done_evt(block_done_evt[c]),
        .cell_done_evt(cell_done_evt[c]),
        .abort_evt(abort_evt[c]),
        .addr_err_evt(addr_err_evt[c]),
        .set_evt(set_w[c])
      );

      assign ch_wr[c] = wr_en && ch_hit && (ch_idx == WW'(c));

      // only lane 2 lands; lane 3 has no storage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          en_q[c] <= DCIC_EN_RST;
        end else if (ch_wr[c] && pstrb[DCIC_EN_LANE]) begin
          en_q[c] <= pwdata[DCIC_EN_LSB +: 8];
        end
      end

      // software may write any flag value, but a hardware set in the
      // same cycle overrides a written zero
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flg_q[c] <= DCIC_FLG_RST;
        end else if (ch_wr[c] && pstrb[DCIC_FLG_LANE]) begin
          flg_q[c] <= pwdata[DCIC_FLG_LSB +: 8] | set_w[c];
        end else begin
          flg_q[c] <= flg_q[c] | set_w[c];
        end
      end

      assign chan_irq[c] = |(flg_q[c] & en_q[c]);

      a_en_store: assert property (
        @(posedge pclk) disable iff (!presetn)
        ch_wr[c] && pstrb[DCIC_EN_LANE]
        |=> en_q[c] == $past(pwdata[23:16]))
        else $error("enable byte not stored");

      // the same write may clear the flag through lane 0
      a_dst_half_en: assert property (
        @(posedge pclk) disable iff (!presetn)
        ch_wr[c] && pstrb[DCIC_EN_LANE] && pwdata[20] &&
        flg_q[c][DCIC_EV_DST_HALF] &&
        (pwdata[DCIC_EV_DST_HALF] || !pstrb[DCIC_FLG_LANE])
        |=> en_q[c][DCIC_EV_DST_HALF] && chan_irq[c])
        else $error("bit 20 does not enable destination half");

      a_src_done_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        set_w[c][DCIC_EV_SRC_DONE] |=> flg_q[c][DCIC_EV_SRC_DONE])
        else $error("source done flag lost");

      a_src_half_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        set_w[c][DCIC_EV_SRC_HALF] |=> flg_q[c][DCIC_EV_SRC_HALF])
        else $error("source half flag lost");

      a_dst_done_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        set_w[c][DCIC_EV_DST_DONE] |=> flg_q[c][DCIC_EV_DST_DONE])
        else $error("destination done flag lost");

      sequence s_read_ch;
        acc_setup && !pwrite && ch_hit && (ch_idx == WW'(c));
      endsequence

      a_flag_readback: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_read_ch |=> prdata[7:0] == $past(flg_q[c]) &&
        prdata[23:16] == $past(en_q[c]))
        else $error("channel word read back wrong");

      a_reset_clear: assert property (
        @(posedge pclk)
        $rose(presetn) |-> en_q[c] == 8'h00 && flg_q[c] == 8'h00)
        else $error("channel bits not zero after reset");

      a_irq_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        set_w[c][DCIC_EV_ADDR_ERR] && en_q[c][DCIC_EV_ADDR_ERR] &&
        !ch_wr[c] |=> chan_irq[c])
        else $error("enabled event raised no request");

      a_irq_drop: assert property (
        @(posedge pclk) disable iff (!presetn)
        ch_wr[c] && pstrb == 4'hF && set_w[c] == 8'h00 &&
        (pwdata[7:0] & pwdata[23:16]) == 8'h00
        |=> !chan_irq[c])
        else $error("request held with no enabled flag");

      // pointer lands on a mark, pulse next cycle, sticky flag after that
      sequence s_src_end;
        $past(presetn) &&
        $rose(source_pointer[c*PW +: PW] == source_size[c*PW +: PW]);
      endsequence

      sequence s_src_mid;
        $past(presetn) &&
        $rose(source_pointer[c*PW +: PW] == (source_size[c*PW +: PW] >> 1));
      endsequence

      sequence s_dst_end;
        $past(presetn) &&
        $rose(destination_pointer[c*PW +: PW] ==
              destination_size[c*PW +: PW]);
      endsequence

      a_src_end_path: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_src_end |-> ##2 flg_q[c][DCIC_EV_SRC_DONE])
        else $error("source end did not reach the flag");

      a_src_mid_path: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_src_mid |-> ##2 flg_q[c][DCIC_EV_SRC_HALF])
        else $error("source midpoint did not reach the flag");

      a_dst_end_path: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_dst_end |-> ##2 flg_q[c][DCIC_EV_DST_DONE])
        else $error("destination end did not reach the flag");

      a_en_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(ch_wr[c] && pstrb[DCIC_EN_LANE]) |=> $stable(en_q[c]))
        else $error("enable byte changed without a write");

      a_flag_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(ch_wr[c] && pstrb[DCIC_FLG_LANE])
        |=> flg_q[c] == ($past(flg_q[c]) | $past(set_w[c])))
        else $error("flag byte changed without a write or event");

      a_flag_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        ch_wr[c] && pstrb[DCIC_FLG_LANE]
        |=> flg_q[c] == ($past(pwdata[7:0]) | $past(set_w[c])))
        else $error("written flag byte not stored");

      a_pad_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_read_ch |=> prdata[31:24] == 8'h00 && prdata[15:8] == 8'h00)
        else $error("unimplemented bits of channel word not zero");

      a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
        chan_rise[c] |=> gst_q[c])
        else $error("rising request missed in global status");

      a_status_w1c: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && st_hit && lane_mask[c] && pwdata[c] && !chan_rise[c]
        |=> !gst_q[c])
        else $error("global status bit not cleared by a one");
    end
  endgenerate

  // global summary: a channel request rising sets a sticky bit
  always_comb begin
    chan_rise = chan_irq & ~chan_irq_q;
    st_clr = '0;
    if (wr_en && st_hit) begin
      st_clr = pwdata[NUM_CH-1:0] & lane_mask[NUM_CH-1:0];
    end
    gst_d = (gst_q & ~st_clr) | chan_rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_irq_q <= DCIC_GBL_RST[NUM_CH-1:0];
    end else begin
      chan_irq_q <= chan_irq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gst_q <= DCIC_GBL_RST[NUM_CH-1:0];
    end else begin
      gst_q <= gst_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gmask_q <= DCIC_GBL_RST[NUM_CH-1:0];
    end else if (wr_en && mk_hit) begin
      gmask_q <= (gmask_q & ~lane_mask[NUM_CH-1:0]) |
                 (pwdata[NUM_CH-1:0] & lane_mask[NUM_CH-1:0]);
    end
  end

  assign irq = |(gst_q & gmask_q);

  a_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_phase && !pwrite && ch_hit |-> prdata[31:24] == 8'h00)
    else $error("bits 31:24 not zero");

  a_middle_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_phase && !pwrite && ch_hit |-> prdata[15:8] == 8'h00)
    else $error("bits 15:8 not zero");

  a_mask_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && mk_hit && pstrb[0] |=> gmask_q[0] == $past(pwdata[0]))
    else $error("global mask bit not stored");

  // a refused write must leave the enable bytes and the global mask alone
  a_unmapped_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    acc_phase && pwrite && !map_hit |=> $stable(en_q) && $stable(gmask_q))
    else $error("unmapped write changed a register");

  a_gbl_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(chan_irq[0]) |=> gst_q[0] ##1 gst_q[0] || $past(st_clr[0]))
    else $error("global status missed a rising request");

endmodule

// File: verilog/dcic_pkg.sv
package dcic_pkg;

  // apb address width and register map
  localparam int unsigned DCIC_AW = 8;
  localparam logic [DCIC_AW-1:0] DCIC_CH_BASE_OFS = 8'h00;
  localparam logic [DCIC_AW-1:0] DCIC_STATUS_OFS = 8'h40;
  localparam logic [DCIC_AW-1:0] DCIC_MASK_OFS = 8'h44;
  localparam logic [DCIC_AW-1:0] DCIC_PEND_OFS = 8'h48;
  localparam int unsigned DCIC_MAX_CH = 16;

  // channel register field positions
  localparam int unsigned DCIC_EN_LSB = 16;
  localparam int unsigned DCIC_FLG_LSB = 0;
  localparam int unsigned DCIC_EN_LANE = 2;
  localparam int unsigned DCIC_FLG_LANE = 0;

  // event bit positions inside each byte
  localparam int unsigned DCIC_EV_SRC_DONE = 7;
  localparam int unsigned DCIC_EV_SRC_HALF = 6;
  localparam int unsigned DCIC_EV_DST_DONE = 5;
  localparam int unsigned DCIC_EV_DST_HALF = 4;
  localparam int unsigned DCIC_EV_BLOCK_DONE = 3;
  localparam int unsigned DCIC_EV_CELL_DONE = 2;
  localparam int unsigned DCIC_EV_ABORT = 1;
  localparam int unsigned DCIC_EV_ADDR_ERR = 0;

  // reset values
  localparam logic [7:0] DCIC_EN_RST = 8'h00;
  localparam logic [7:0] DCIC_FLG_RST = 8'h00;
  localparam logic [DCIC_MAX_CH-1:0] DCIC_GBL_RST = 16'h0000;
  localparam logic [3:0] DCIC_EQ_RST = 4'hF;

endpackage

// File: verilog/dcic_event_detect.sv
`timescale 1ns/10ps
module dcic_event_detect #(
  parameter int PW = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pointer datapath
  input wire logic [PW-1:0] source_pointer,
  input wire logic [PW-1:0] source_size,
  input wire logic [PW-1:0] destination_pointer,
  input wire logic [PW-1:0] destination_size,
  // single-cycle datapath events
  input wire logic block_done_evt,
  input wire logic cell_done_evt,
  input wire logic abort_evt,
  input wire logic addr_err_evt,
  // one-cycle set pulses, flag byte layout
  output logic [7:0] set_evt
);
  import dcic_pkg::*;

  logic [3:0] eq_now;
  logic [3:0] eq_q;
  logic [3:0] hit;

  // a pointer parked on its mark sets the flag once, not every cycle
  always_comb begin
    eq_now[3] = source_pointer == source_size;
    eq_now[2] = source_pointer == (source_size >> 1);
    eq_now[1] = destination_pointer == destination_size;
    eq_now[0] = destination_pointer == (destination_size >> 1);
    hit = eq_now & ~eq_q;
  end

  // preset high so pointers already equal at reset raise nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_q <= DCIC_EQ_RST;
    end else begin
      eq_q <= eq_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_evt <= DCIC_FLG_RST;
    end else begin
      set_evt <= {hit, block_done_evt, cell_done_evt, abort_evt,
                  addr_err_evt};
    end
  end

  a_src_done_detect: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $rose(source_pointer == source_size)
    |=> set_evt[DCIC_EV_SRC_DONE])
    else $error("source end reached without done pulse");

  a_src_half_detect: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $rose(source_pointer == (source_size >> 1))
    |=> set_evt[DCIC_EV_SRC_HALF])
    else $error("source midpoint reached without half pulse");

  a_dst_done_detect: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $rose(destination_pointer == destination_size)
    |=> set_evt[DCIC_EV_DST_DONE])
    else $error("destination end reached without done pulse");

endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import dcic_pkg::*;
  localparam int NCH = 4;
  localparam int PW = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [DCIC_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0] pstrb, s;
  logic [NCH*PW-1:0] sp, ss, dp, ds;
  logic [NCH-1:0] bde, cde, abe, aee, chan_irq;
  logic [15:0] s1, s2;
  logic [7:0] fl;
  logic [31:0] shadow [NCH];
  int n_errors, checks_done, seed, c, k;

  dcic_top #(.NUM_CH(NCH), .PW(PW)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .source_pointer(sp), .source_size(ss),
    .destination_pointer(dp), .destination_size(ds),
    .block_done_evt(bde), .cell_done_evt(cde), .abort_evt(abe),
    .addr_err_evt(aee), .chan_irq(chan_irq), .irq(irq));

  always #2.5 pclk = ~pclk;

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // entered just after an edge; ends one idle cycle later
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           input logic [3:0] st);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= a; pwdata <= wd; pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(0, 1, "no pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] v,
                                        logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    return ((o & ~m) | (v & m)) & 32'h00FF00FF;
  endfunction

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #(20000 * 5);
    n_errors++;
    final_report();
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; pstrb = '0; sp = '0; ss = '0; dp = '0; ds = '0;
    bde = '0; cde = '0; abe = '0; aee = '0; seed = 32'h517d;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (c = 0; c < NCH; c++) begin
      apb(0, 8'(4 * c), 0, 0);
      chk(rd, 0, "reset word");
      chk({31'b0, err}, 0, "mapped err");
    end
    apb(0, DCIC_STATUS_OFS, 0, 0);
    chk(rd, 0, "reset status");
    $display("test reset done");
    for (c = 0; c < NCH; c++) begin
      apb(1, 8'(4 * c), 32'h00110000, 4'hF);
      s1 = 16'($random(seed));
      s2 = 16'($random(seed));
      s1 = {1'b0, s1[14:2], 2'b00} | 16'h0008;
      s2 = {1'b0, s2[14:2], 2'b00} | 16'h0008;
      ss[c*PW +: PW] <= s1;
      ds[c*PW +: PW] <= s2;
      repeat (3) @(posedge pclk);
      fl = 8'h00;
      // pointer marks in order: src half, src end, dst half, dst end
      for (k = 0; k < 4; k++) begin
        case (k)
          0: sp[c*PW +: PW] <= s1 >> 1;
          1: sp[c*PW +: PW] <= s1;
          2: dp[c*PW +: PW] <= s2 >> 1;
          default: dp[c*PW +: PW] <= s2;
        endcase
        fl = fl | ((k == 0) ? 8'h40 : (k == 1) ? 8'h80 :
                   (k == 2) ? 8'h10 : 8'h20);
        repeat (3) @(posedge pclk);
        apb(0, 8'(4 * c), 0, 0);
        chk(rd, {16'h0011, 8'h00, fl}, "pointer flag");
        chk({31'b0, chan_irq[c]}, {31'b0, fl[4]}, "chan irq");
      end
      for (k = 0; k < 4; k++) begin
        {bde[c], cde[c], abe[c], aee[c]} <= 4'b1000 >> k;
        @(posedge pclk);
        {bde[c], cde[c], abe[c], aee[c]} <= 4'b0000;
        @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
      apb(0, 8'(4 * c), 0, 0);
      chk(rd, 32'h001100FF, "pulse flags");
      apb(1, 8'(4 * c), 32'hFFFFFFFF, 4'b0100);
      apb(0, 8'(4 * c), 0, 0);
      chk(rd, 32'h00FF00FF, "enable lane");
      apb(0, DCIC_PEND_OFS, 0, 0);
      chk(rd, 32'(1) << c, "pending");
      apb(0, DCIC_STATUS_OFS, 0, 0);
      chk(rd, 32'(1) << c, "status");
      chk({31'b0, irq}, 0, "irq masked");
      apb(1, DCIC_MASK_OFS, 32'(1) << c, 4'hF);
      chk({31'b0, irq}, 1, "irq unmasked");
      apb(1, 8'(4 * c), 0, 4'b0001);
      chk({31'b0, chan_irq[c]}, 0, "flags cleared");
      apb(1, DCIC_STATUS_OFS, 32'(1) << c, 4'hF);
      chk({31'b0, irq}, 0, "status w1c");
      apb(1, 8'(4 * c), 0, 4'hF);
      apb(1, DCIC_MASK_OFS, 0, 4'hF);
      shadow[c] = 0;
    end
    $display("test events done");
    // random lanes; pointers stay put so no event can disturb the shadow
    for (k = 0; k < 40; k++) begin
      c = {$random(seed)} % NCH;
      d = $random(seed);
      s = 4'($random(seed));
      if (k < 2) s = 4'hF;
      apb(1, 8'(4 * c), d, s);
      shadow[c] = merge(shadow[c], d, s);
      apb(0, 8'(4 * c), 0, 0);
      chk(rd, shadow[c], "readback");
    end
    $display("test random done");
    for (k = 0; k < 2; k++) begin
      apb(1, k ? 8'h4C : 8'h10, 32'hFFFFFFFF, 4'hF);
      chk({31'b0, err}, 1, "unmapped write err");
      apb(0, k ? 8'h4C : 8'h10, 0, 0);
      chk(rd, 0, "unmapped read");
      chk({31'b0, err}, 1, "unmapped read err");
    end
    $display("test unmapped done");
    final_report();
  end
endmodule
